/* dv/asef_flags_bench.sv */
`timescale 1ns/100ps
`include "asef_defines.svh"
`default_nettype none

module asef_flags_bench;
  import asef_pkg::*;
  localparam int TICK = 10 * (`ASEF_RST_FLT + 1);
  logic clk, rst, irq, reconfig, overrange_detect_en, accum_en, conv_valid, overrange_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, conv_result, accum_value, rd_q;
  logic [3:0] s_axi_wstrb, gain;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total, n_compared;

  // Short timers keep the run small
  asef_flags #(.TICK_STEP_CYC(10), .OVR_CYC(8)) dut_u (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_valid, .conv_result,
    .accum_value, .overrange_pin, .irq, .reconfig, .gain, .overrange_detect_en,
    .accum_en
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang;
    err_total++;
    print_verdict();
  endtask

  // Ready lines stay high: legal and avoids double drives between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && i < 40);
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    if (i >= 40) hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && i < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (i >= 40) hang();
  endtask

  task automatic rck(input string w, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    rd(a, rd_q, rsp);
    check(w, rd_q & m, exp);
  endtask

  task automatic conv(input logic [31:0] v);
    conv_result <= v;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_result, accum_value} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, conv_valid, overrange_pin} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    err_total = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rck("msk", `ASEF_OFF_MSK, 32'hffff_ffff, `ASEF_RST_MSK);
    rck("flt", `ASEF_OFF_FLT, 32'hffff_ffff, `ASEF_RST_FLT);
    rck("thc", `ASEF_OFF_THC, 32'hffff_ffff, `ASEF_RST_THC);
    wr(`ASEF_OFF_STA, 32'hffff_ffff, ASEF_RESP_SLVERR);
    rck("sta", `ASEF_OFF_STA, 32'hffff_ffff, 32'h0);
    rd(8'h44, rd_q, rsp);
    check("unm", {rd_q[29:0], rsp}, {30'h0, ASEF_RESP_SLVERR});
    // Periodic tick in always mode, restarted by the write
    wr(`ASEF_OFF_MODE, 32'h1, ASEF_RESP_OKAY);
    repeat (TICK - 10) @(posedge clk);
    rck("tick_early", `ASEF_OFF_STA, 32'h40, 32'h0);
    repeat (15) @(posedge clk);
    rck("tick", `ASEF_OFF_STA, 32'h41, 32'h40);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(`ASEF_OFF_MSK, 32'h40, ASEF_RESP_OKAY);
    repeat (2) @(posedge clk);
    check("irq_on", {31'h0, irq}, 32'h1);
    rck("dat_rd", `ASEF_OFF_DAT, 32'hffff_ffff, 32'h0);
    repeat (2) @(posedge clk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    rck("tick_clr", `ASEF_OFF_STA, 32'h40, 32'h0);
    // Ready held off over the first two ticks; software trusts ready only
    wr(`ASEF_OFF_MODE, 32'h1, ASEF_RESP_OKAY);
    repeat (TICK + 20) @(posedge clk);
    conv(32'h0000_1234);
    rck("rdy_t1", `ASEF_OFF_STA, 32'h1, 32'h0);
    repeat (TICK - 10) @(posedge clk);
    conv(32'h0000_0abc);
    rck("rdy_t2", `ASEF_OFF_STA, 32'h1, 32'h1);
    rck("dat", `ASEF_OFF_DAT, 32'hffff_ffff, 32'h0000_0abc);
    // Accumulator comparator, boundary then clears
    wr(`ASEF_OFF_ATH, 32'h64, ASEF_RESP_OKAY);
    accum_value <= 32'hffff_ff9c;
    wr(`ASEF_OFF_CFG, 32'h22, ASEF_RESP_OKAY);
    // Enable output is registered after the write lands
    @(posedge clk);
    check("acc_en", {31'h0, accum_en}, 32'h1);
    rck("ath_eq", `ASEF_OFF_STA, 32'h20, 32'h0);
    accum_value <= 32'hffff_ff9b;
    repeat (3) @(posedge clk);
    rck("ath_gt", `ASEF_OFF_STA, 32'h20, 32'h20);
    accum_value <= 32'h0;
    wr(`ASEF_OFF_CFG, 32'h20, ASEF_RESP_OKAY);
    rck("ath_dis", `ASEF_OFF_STA, 32'h20, 32'h0);
    accum_value <= 32'h65;
    wr(`ASEF_OFF_CFG, 32'h22, ASEF_RESP_OKAY);
    accum_value <= 32'h0;
    rck("ath_set", `ASEF_OFF_STA, 32'h20, 32'h20);
    wr(`ASEF_OFF_FLT, `ASEF_RST_FLT, ASEF_RESP_OKAY);
    rck("ath_rcf", `ASEF_OFF_STA, 32'h20, 32'h0);
    // Result comparator with a count of three
    wr(`ASEF_OFF_TH, 32'h32, ASEF_RESP_OKAY);
    wr(`ASEF_OFF_THC, 32'h3, ASEF_RESP_OKAY);
    wr(`ASEF_OFF_CFG, 32'h1, ASEF_RESP_OKAY);
    conv(32'h33);
    conv(32'h33);
    conv(32'h32);
    rck("thv_zero", `ASEF_OFF_THV, 32'hffff_ffff, 32'h0);
    conv(32'h33);
    conv(32'hffff_ffc4);
    rck("th_two", `ASEF_OFF_STA, 32'h10, 32'h0);
    conv(32'hffff_ffcd);
    rck("th_three", `ASEF_OFF_STA, 32'h10, 32'h10);
    wr(`ASEF_OFF_CFG, 32'h0, ASEF_RESP_OKAY);
    rck("th_dis", `ASEF_OFF_STA, 32'h10, 32'h0);
    conv(32'h63);
    conv(32'h63);
    conv(32'h63);
    rck("th_off", `ASEF_OFF_STA, 32'h10, 32'h0);
    // Fast overrange: periodic update, cleared only by a gain change
    wr(`ASEF_OFF_CTRL, 32'h12, ASEF_RESP_OKAY);
    @(posedge clk);
    check("gain", {28'h0, gain}, 32'h2);
    check("ovr_en", {31'h0, overrange_detect_en}, 32'h1);
    overrange_pin <= 1'b1;
    repeat (20) @(posedge clk);
    rck("ovr_set", `ASEF_OFF_STA, 32'h8, 32'h8);
    overrange_pin <= 1'b0;
    wr(`ASEF_OFF_CTRL, 32'h12, ASEF_RESP_OKAY);
    repeat (20) @(posedge clk);
    rck("ovr_keep", `ASEF_OFF_STA, 32'h8, 32'h8);
    wr(`ASEF_OFF_CTRL, 32'h3, ASEF_RESP_OKAY);
    rck("ovr_clr", `ASEF_OFF_STA, 32'h8, 32'h0);
    overrange_pin <= 1'b1;
    repeat (20) @(posedge clk);
    rck("ovr_off", `ASEF_OFF_STA, 32'h8, 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire

/* dv/asef_flags_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module asef_flags_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reconfig,
  input wire logic [3:0] gain,
  input wire logic overrange_detect_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Bus sequences
  // ----------------------------------------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_b_lat;
    s_wr_take |=> s_b_late;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_w_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h44
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // Reconfig stands with the first cycle of an OKAY answer, one cycle only
  property p_reconfig;
    reconfig |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'b00 ##1 !reconfig;
  endproperty
  // Control outputs move only the cycle after a reconfiguring write
  property p_gain;
    $changed(gain) |-> $past(reconfig);
  endproperty
  property p_ovr_en;
    $changed(overrange_detect_en) |-> $past(reconfig);
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer off by cycles");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_w_refused: assert property (p_w_refused) else $error("write ready while answer pends");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_reconfig: assert property (p_reconfig) else $error("stray reconfig pulse");
  a_gain: assert property (p_gain) else $error("gain moved without write");
  a_ovr_en: assert property (p_ovr_en) else $error("detect enable moved");
endmodule

bind asef_flags asef_flags_chk chk_u (
  .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .reconfig, .gain, .overrange_detect_en
);

`default_nettype wire

/* rtl/asef_defines.svh */
`ifndef ASEF_DEFINES_SVH
`define ASEF_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ASEF_OFF_STA 8'h00
`define ASEF_OFF_MSK 8'h04
`define ASEF_OFF_MODE 8'h08
`define ASEF_OFF_CTRL 8'h0c
`define ASEF_OFF_FLT 8'h18
`define ASEF_OFF_CFG 8'h1c
`define ASEF_OFF_DAT 8'h20
`define ASEF_OFF_TH 8'h50
`define ASEF_OFF_THC 8'h54
`define ASEF_OFF_THV 8'h58
`define ASEF_OFF_ACC 8'h5c
`define ASEF_OFF_ATH 8'h60

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASEF_STA_RDY 0
`define ASEF_STA_OVR 3
`define ASEF_STA_THEX 4
`define ASEF_STA_ATHEX 5
`define ASEF_STA_TICK 6
`define ASEF_MODE_ALWAYS 0
`define ASEF_CTRL_GAIN_MSB 3
`define ASEF_CTRL_OVR_EN 4
`define ASEF_CFG_TH_EN 0
`define ASEF_CFG_ATH_EN 1
`define ASEF_CFG_ACC_EN 5
`define ASEF_FLT_MSB 7
`define ASEF_THC_MSB 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASEF_RST_ZERO 32'h0000_0000
`define ASEF_RST_MSK 32'h0000_0000
`define ASEF_RST_FLT 32'h0000_0007
`define ASEF_RST_THC 32'h0000_0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASEF_CLK_PERIOD_NS 100
`define ASEF_TICK_DEFAULT_NS 1000000
`define ASEF_TICK_STEP_CYC \
  (`ASEF_TICK_DEFAULT_NS / ((`ASEF_RST_FLT + 1) * `ASEF_CLK_PERIOD_NS))
`define ASEF_OVR_PERIOD_NS 125000
`define ASEF_OVR_CYC (`ASEF_OVR_PERIOD_NS / `ASEF_CLK_PERIOD_NS)
`define ASEF_RDY_SKIP_TICKS 2'h2

`endif

/* rtl/asef_flags.sv */
// How it works
// R1: A read of the current result register clears the periodic tick flag in status bit 6.
// R2: In always-interrupt mode the tick flag is raised once per output period, settled or not.
// R3: With the filter setting at its reset value the tick comes every 1.0 ms.
// R4: After a reconfiguration the ready flag cannot set before the second tick.
// R5: Software decides result validity from the ready flag, never from the tick alone.
// R6: Any reconfiguration of the current converter restarts the tick timebase.
// R7: Status bit 5 sets when the accumulator magnitude exceeds the accumulator threshold.
// R8: Bit 5 clears on reconfiguration or while the accumulator comparator is disabled.
// R9: Status bit 4 sets when a result magnitude exceeds the result threshold.
// R10: Bit 4 reports nothing while the result comparator is disabled.
// R11: Bit 4 clears on reconfiguration or while the result comparator is disabled.
// R12: Bit 4 sets only after the programmed count of exceeding conversions.
// R13: Status bit 3 sets when overrange detection is on and the input is grossly overrange.
// R14: Bit 3 is re-evaluated on a fixed 125 us period.
// R15: Bit 3 clears when software changes the gain setting.
// R16: The tick flag interrupts only when its mask bit is set; the mask resets to zero.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "asef_defines.svh"
`default_nettype none

module asef_flags
  import asef_pkg::*;
#(
  parameter int TICK_STEP_CYC = `ASEF_TICK_STEP_CYC,
  parameter int OVR_CYC = `ASEF_OVR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_valid,
  input wire logic [31:0] conv_result,
  input wire logic [31:0] accum_value,
  input wire logic overrange_pin,
  output logic irq,
  output logic reconfig,
  output logic [3:0] gain,
  output logic overrange_detect_en,
  output logic accum_en
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic asef_word_t merge_bytes(asef_word_t old, asef_word_t nw,
                                             logic [3:0] strb);
    asef_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Signed twos complement magnitude; the most negative value maps to itself, 2^31 unsigned
  function automatic asef_word_t magnitude(asef_word_t v);
    return v[31] ? (~v + 32'h1) : v;
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic aw_full_q;
  logic w_full_q;
  asef_addr_t aw_addr_q;
  asef_word_t w_data_q;
  logic [3:0] w_strb_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  wire b_done = s_axi_bvalid && s_axi_bready;

  wire wr_msk = do_write && (aw_addr_q == `ASEF_OFF_MSK);
  wire wr_mode = do_write && (aw_addr_q == `ASEF_OFF_MODE);
  wire wr_ctrl = do_write && (aw_addr_q == `ASEF_OFF_CTRL);
  wire wr_flt = do_write && (aw_addr_q == `ASEF_OFF_FLT);
  wire wr_cfg = do_write && (aw_addr_q == `ASEF_OFF_CFG);
  wire wr_th = do_write && (aw_addr_q == `ASEF_OFF_TH);
  wire wr_thc = do_write && (aw_addr_q == `ASEF_OFF_THC);
  wire wr_ath = do_write && (aw_addr_q == `ASEF_OFF_ATH);
  wire wr_hit = wr_msk || wr_mode || wr_ctrl || wr_flt || wr_cfg || wr_th || wr_thc
                || wr_ath;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ASEF_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ASEF_RESP_OKAY : ASEF_RESP_SLVERR;
      end
      // Ready returns only after the response, so one write at a time
      if (b_done) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  asef_word_t msk_q;
  asef_word_t mode_q;
  asef_word_t ctrl_q;
  asef_word_t flt_q;
  asef_word_t cfg_q;
  asef_word_t th_q;
  asef_word_t thc_q;
  asef_word_t ath_q;

  wire asef_word_t ctrl_new = merge_bytes(ctrl_q, w_data_q, w_strb_q);
  // Writing any current-converter setting counts as a reconfiguration
  wire reconfig_now = wr_mode || wr_ctrl || wr_flt;
  wire gain_change = wr_ctrl &&
                     (ctrl_new[`ASEF_CTRL_GAIN_MSB:0] != ctrl_q[`ASEF_CTRL_GAIN_MSB:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msk_q <= `ASEF_RST_MSK; // see R16
      mode_q <= `ASEF_RST_ZERO;
      ctrl_q <= `ASEF_RST_ZERO;
      flt_q <= `ASEF_RST_FLT;
      cfg_q <= `ASEF_RST_ZERO;
      th_q <= `ASEF_RST_ZERO;
      thc_q <= `ASEF_RST_THC;
      ath_q <= `ASEF_RST_ZERO;
    end else begin
      if (wr_msk) msk_q <= merge_bytes(msk_q, w_data_q, w_strb_q);
      if (wr_mode) mode_q <= merge_bytes(mode_q, w_data_q, w_strb_q);
      if (wr_ctrl) ctrl_q <= ctrl_new;
      if (wr_flt) flt_q <= merge_bytes(flt_q, w_data_q, w_strb_q);
      if (wr_cfg) cfg_q <= merge_bytes(cfg_q, w_data_q, w_strb_q);
      if (wr_th) th_q <= merge_bytes(th_q, w_data_q, w_strb_q);
      if (wr_thc) thc_q <= merge_bytes(thc_q, w_data_q, w_strb_q);
      if (wr_ath) ath_q <= merge_bytes(ath_q, w_data_q, w_strb_q);
    end
  end

  wire always_mode = mode_q[`ASEF_MODE_ALWAYS];
  wire th_en = cfg_q[`ASEF_CFG_TH_EN];
  wire ath_en = cfg_q[`ASEF_CFG_ATH_EN];
  wire ovr_en = ctrl_q[`ASEF_CTRL_OVR_EN];

  // ----------------------------------------
  // Timebases
  // ----------------------------------------
  logic tick_pulse;
  logic ovr_strobe;
  logic ovr_level;

  // Period scales with the filter setting; reset value gives 1.0 ms
  wire [31:0] tick_prod = (32'(flt_q[`ASEF_FLT_MSB:0]) + 32'h1) * 32'(TICK_STEP_CYC); // see R3
  wire [23:0] tick_period = tick_prod[23:0];

  asef_timer #(.W(24)) u_tick_timer (
    .clk(clk),
    .rst(rst),
    .restart(reconfig_now), // see R6
    .period(tick_period),
    .pulse(tick_pulse)
  );

  // Free running; never restarted by software
  asef_timer #(.W(24)) u_ovr_timer (
    .clk(clk),
    .rst(rst),
    .restart(1'b0),
    .period(24'(OVR_CYC)), // see R14
    .pulse(ovr_strobe)
  );

  // Analog comparator output is asynchronous to clk
  asef_sync3 u_ovr_sync (
    .clk(clk),
    .rst(rst),
    .d(overrange_pin),
    .q(ovr_level)
  );

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire rd_dat = ar_take && (s_axi_araddr == `ASEF_OFF_DAT);

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic tick_q;
  logic athex_q;
  logic thex_q;
  logic ovr_q;
  logic rdy_q;
  logic [1:0] ticks_q;
  logic [`ASEF_THC_MSB:0] thv_q;
  asef_word_t dat_q;

  wire res_exceed = magnitude(conv_result) > th_q; // see R9
  wire acc_exceed = magnitude(accum_value) > ath_q; // see R7
  wire [`ASEF_THC_MSB:0] thv_inc = thv_q + 8'h01;
  // A zero limit behaves as one
  wire thc_met = (thv_inc >= thc_q[`ASEF_THC_MSB:0]) || (thv_inc == 8'hff); // see R12

  wire tick_set = tick_pulse && always_mode; // see R2
  wire athex_set = ath_en && acc_exceed;
  wire athex_clr = reconfig_now || !ath_en; // see R8
  wire thex_set = th_en && conv_valid && res_exceed && thc_met; // see R10
  wire thex_clr = reconfig_now || !th_en; // see R11
  wire ovr_set = ovr_strobe && ovr_en && ovr_level; // see R13
  wire rdy_allowed = (ticks_q >= `ASEF_RDY_SKIP_TICKS);
  wire rdy_set = conv_valid && !rdy_q && rdy_allowed; // see R4
  wire rdy_clr = rd_dat || reconfig_now;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
      athex_q <= 1'b0;
      thex_q <= 1'b0;
      ovr_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      // Set always beats a clear in the same cycle
      tick_q <= tick_set || (tick_q && !rd_dat); // see R1
      athex_q <= athex_set || (athex_q && !athex_clr);
      thex_q <= thex_set || (thex_q && !thex_clr);
      ovr_q <= ovr_set || (ovr_q && !gain_change); // see R15
      rdy_q <= rdy_set || (rdy_q && !rdy_clr);
    end
  end

  // Tick count since reconfiguration, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ticks_q <= 2'h0;
    end else if (reconfig_now) begin
      ticks_q <= 2'h0; // see R4
    end else if (tick_pulse && !rdy_allowed) begin
      ticks_q <= ticks_q + 2'h1;
    end
  end

  // Consecutive exceeding conversions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thv_q <= '0;
    end else if (thex_clr) begin
      thv_q <= '0;
    end else if (conv_valid) begin
      thv_q <= res_exceed ? (thc_met ? thv_q : thv_inc) : '0; // see R12
    end
  end

  // A held ready flag blocks further result updates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_q <= '0;
    end else if (conv_valid && !rdy_q) begin
      dat_q <= conv_result;
    end
  end

  asef_word_t sta_word;
  always_comb begin
    sta_word = '0;
    sta_word[`ASEF_STA_RDY] = rdy_q;
    sta_word[`ASEF_STA_OVR] = ovr_q;
    sta_word[`ASEF_STA_THEX] = thex_q;
    sta_word[`ASEF_STA_ATHEX] = athex_q;
    sta_word[`ASEF_STA_TICK] = tick_q;
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire asef_addr_t ra = s_axi_araddr;
  wire rd_hit = (ra == `ASEF_OFF_STA) || (ra == `ASEF_OFF_MSK) || (ra == `ASEF_OFF_MODE)
                || (ra == `ASEF_OFF_CTRL) || (ra == `ASEF_OFF_FLT) || (ra == `ASEF_OFF_CFG)
                || (ra == `ASEF_OFF_DAT) || (ra == `ASEF_OFF_TH) || (ra == `ASEF_OFF_THC)
                || (ra == `ASEF_OFF_THV) || (ra == `ASEF_OFF_ACC) || (ra == `ASEF_OFF_ATH);
  wire asef_word_t rd_word =
    (ra == `ASEF_OFF_STA) ? sta_word :
    (ra == `ASEF_OFF_MSK) ? msk_q :
    (ra == `ASEF_OFF_MODE) ? mode_q :
    (ra == `ASEF_OFF_CTRL) ? ctrl_q :
    (ra == `ASEF_OFF_FLT) ? flt_q :
    (ra == `ASEF_OFF_CFG) ? cfg_q :
    (ra == `ASEF_OFF_DAT) ? dat_q :
    (ra == `ASEF_OFF_TH) ? th_q :
    (ra == `ASEF_OFF_THC) ? thc_q :
    (ra == `ASEF_OFF_THV) ? 32'(thv_q) :
    (ra == `ASEF_OFF_ACC) ? accum_value :
    (ra == `ASEF_OFF_ATH) ? ath_q : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ASEF_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? ASEF_RESP_OKAY : ASEF_RESP_SLVERR;
      end
      if (r_done) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
      reconfig <= 1'b0;
      gain <= '0;
      overrange_detect_en <= 1'b0;
      accum_en <= 1'b0;
    end else begin
      irq <= |(sta_word & msk_q); // see R16
      reconfig <= reconfig_now;
      gain <= ctrl_q[`ASEF_CTRL_GAIN_MSB:0];
      overrange_detect_en <= ovr_en;
      accum_en <= cfg_q[`ASEF_CFG_ACC_EN];
    end
  end

endmodule

`default_nettype wire

/* rtl/asef_pkg.sv */
package asef_pkg;

  typedef logic [31:0] asef_word_t;
  typedef logic [7:0] asef_addr_t;

  typedef enum logic [1:0] {
    ASEF_RESP_OKAY = 2'b00,
    ASEF_RESP_SLVERR = 2'b10
  } asef_resp_t;

endpackage

/* rtl/asef_sync3.sv */
`timescale 1ns/100ps
`default_nettype none

module asef_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/asef_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module asef_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [W-1:0] period,
  output logic pulse
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire last = (cnt_q == W'(1));

  // Zero count reloads, so the first pulse comes one full period after start
  assign cnt_d = (restart || cnt_q <= W'(1)) ? period : cnt_q - W'(1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse <= last && !restart;
    end
  end

endmodule

`default_nettype wire
